// ---- tcc_defines.svh ----
// Contract
// - Ch4 capture, bits 2:0 all zero: latch counter on rising pin edge.
// - Ch4 capture, bit0 set, bits 2,1 clear: latch on falling pin edge.
// - Ch4 capture, bit2 clear, bit1 set: latch on both pin edges.
// - Ch4 capture, bit2 set: latch on channel 3 register A match or capture.
// - Ch5 compare, bits 1:0 = 01: drive pin low on match.
// - Ch5 compare, bits 1:0 = 10: drive pin high on match.
// - Ch5 compare, bits 1:0 = 11: toggle pin on every match; a match in a ch5InitLoad cycle loads the bit2 level instead.
// - Ch5 bit3 set: capture mode; bits 1:0 = 00 capture on rising edge.
// - Ch5 capture: 01 falling edge, bit1 set both edges.
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
`define TCC_CNT_W 16
`define TCC_BIT_MODE 3
`define TCC_BIT_LVL 2
`define TCC_BIT_SEL1 1
`define TCC_BIT_SEL0 0
`define TCC_REG_RST 16'h0000
`endif

// ---- tcc_pkg.sv ----
package tcc_pkg;
  typedef enum logic [1:0] {TCC_EDGE_RISE, TCC_EDGE_FALL, TCC_EDGE_BOTH} tcc_edge_e;
  typedef logic [3:0] tcc_iosel_t;
endpackage

// ---- tcc_io_control.sv ----
`include "tcc_defines.svh"
module tcc_io_control
  import tcc_pkg::*;
#(
  parameter int CNT_W = `TCC_CNT_W
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [CNT_W-1:0] counter,
  input wire logic [2:0] ch4IoSel,
  input wire logic ch4CaptureMode,
  input wire logic ch4RegAPin,
  input wire logic ch3RegAEvent,
  input wire logic [3:0] ch5IoSel,
  input wire logic ch5InitLoad,
  input wire logic ch5CompareWrite,
  input wire logic [CNT_W-1:0] ch5CompareValue,
  input wire logic ch5RegAPinIn,
  output logic [CNT_W-1:0] ch4GeneralRegA,
  output logic ch4Captured,
  output logic [CNT_W-1:0] ch5GeneralRegA,
  output logic ch5Event,
  output logic ch5RegAPinOut,
  output logic ch5RegAPinOe
);
  localparam int NUM_PINS = 2;
  localparam int PIN_CH4 = 0;
  localparam int PIN_CH5 = 1;

  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // Pin levels and detected edges, one bit per capture pin
  wire logic [NUM_PINS-1:0] pinNow;
  wire logic [NUM_PINS-1:0] pinRise;
  wire logic [NUM_PINS-1:0] pinFall;

  logic [CNT_W-1:0] ch4A_reg;
  logic [CNT_W-1:0] ch4A_next;
  logic ch4Cap_reg;
  logic ch4Cap_next;

  logic [CNT_W-1:0] ch5A_reg;
  logic [CNT_W-1:0] ch5A_next;
  logic ch5Ev_reg;
  logic ch5Ev_next;
  logic out_reg;
  logic out_next;

  tcc_iosel_t ch5Code;
  logic [1:0] ch5Action;
  tcc_edge_e ch4Edge;
  tcc_edge_e ch5Edge;
  logic ch4PinSource;
  logic ch4PinHit;
  logic ch4Hit;
  logic ch5CaptureMode;
  logic ch5PinHit;
  logic ch5CapHit;
  logic ch5Match;
  logic ch5WriteTaken;
  logic ch5OutEnable;

  function automatic logic edgeHit(
    input tcc_edge_e sel,
    input logic rise,
    input logic fall
  );
    unique case (sel)
      TCC_EDGE_RISE: edgeHit = rise;
      TCC_EDGE_FALL: edgeHit = fall;
      TCC_EDGE_BOTH: edgeHit = rise | fall;
      default: edgeHit = 1'b0;
    endcase
  endfunction

  assign pinNow[PIN_CH4] = ch4RegAPin;
  assign pinNow[PIN_CH5] = ch5RegAPinIn;

  // History resets low: a pin already high at release reads as a rising edge
  for (genvar pinIdx = 0; pinIdx < NUM_PINS; pinIdx++) begin : g_pinEdge
    logic pin_reg;
    logic pin_next;

    always_comb begin
      pin_next = pinNow[pinIdx];
    end

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        pin_reg <= 1'b0;
      end else begin
        pin_reg <= pin_next;
      end
    end

    assign pinRise[pinIdx] = pinNow[pinIdx] & ~pin_reg;
    assign pinFall[pinIdx] = ~pinNow[pinIdx] & pin_reg;
  end

  always_comb begin
    ch5Code = ch5IoSel;
    ch5Action = ch5Code[`TCC_BIT_SEL1:`TCC_BIT_SEL0];
    ch5CaptureMode = ch5Code[`TCC_BIT_MODE];
    ch4PinSource = ~ch4IoSel[`TCC_BIT_LVL];
    if (ch4IoSel[`TCC_BIT_SEL1]) begin
      ch4Edge = TCC_EDGE_BOTH;
    end else if (ch4IoSel[`TCC_BIT_SEL0]) begin
      ch4Edge = TCC_EDGE_FALL;
    end else begin
      ch4Edge = TCC_EDGE_RISE;
    end
    ch4PinHit = edgeHit(ch4Edge, pinRise[PIN_CH4], pinFall[PIN_CH4]);
    if (ch4PinSource) begin
      ch4Hit = ch4CaptureMode & ch4PinHit;
    end else begin
      ch4Hit = ch4CaptureMode & ch3RegAEvent;
    end
    if (ch5Code[`TCC_BIT_SEL1]) begin
      ch5Edge = TCC_EDGE_BOTH;
    end else if (ch5Code[`TCC_BIT_SEL0]) begin
      ch5Edge = TCC_EDGE_FALL;
    end else begin
      ch5Edge = TCC_EDGE_RISE;
    end
    ch5PinHit = edgeHit(ch5Edge, pinRise[PIN_CH5], pinFall[PIN_CH5]);
    ch5CapHit = ch5CaptureMode & ch5PinHit;
    // A match only counts while register A is a compare register
    ch5Match = ~ch5CaptureMode & (ch5A_reg == counter);
    // Capture wins over a compare write landing in the same cycle
    ch5WriteTaken = ch5CompareWrite & ~ch5CaptureMode & ~ch5CapHit;
    // Pin driven only in compare mode with a nonzero action code
    ch5OutEnable = ~ch5CaptureMode & (ch5Action != ACT_NONE);
  end

  // Channel 4 captured count
  always_comb begin
    ch4A_next = ch4A_reg;
    if (ch4Hit) begin
      ch4A_next = counter;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ch4A_reg <= CNT_W'(`TCC_REG_RST);
    end else begin
      ch4A_reg <= ch4A_next;
    end
  end

  // Channel 4 one-cycle capture pulse
  always_comb begin
    ch4Cap_next = ch4Hit;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ch4Cap_reg <= 1'b0;
    end else begin
      ch4Cap_reg <= ch4Cap_next;
    end
  end

  // Channel 5 register A: captured count or compare value
  always_comb begin
    ch5A_next = ch5A_reg;
    if (ch5CapHit) begin
      ch5A_next = counter;
    end else if (ch5WriteTaken) begin
      ch5A_next = ch5CompareValue;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ch5A_reg <= CNT_W'(`TCC_REG_RST);
    end else begin
      ch5A_reg <= ch5A_next;
    end
  end

  // One-cycle event for a channel 5 capture or compare match
  always_comb begin
    ch5Ev_next = ch5CapHit | ch5Match;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ch5Ev_reg <= 1'b0;
    end else begin
      ch5Ev_reg <= ch5Ev_next;
    end
  end

  // Channel 5 pin level: initial load first, then the match action
  always_comb begin
    out_next = out_reg;
    if (ch5InitLoad) begin
      out_next = ch5Code[`TCC_BIT_LVL];
    end else if (ch5Match) begin
      unique case (ch5Action)
        ACT_NONE: out_next = out_reg;
        ACT_LOW: out_next = 1'b0;
        ACT_HIGH: out_next = 1'b1;
        ACT_TOGGLE: out_next = ~out_reg;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
    end
  end

  assign ch4GeneralRegA = ch4A_reg;
  assign ch4Captured = ch4Cap_reg;
  assign ch5GeneralRegA = ch5A_reg;
  assign ch5Event = ch5Ev_reg;
  assign ch5RegAPinOut = out_reg;
  assign ch5RegAPinOe = ch5OutEnable;
endmodule // tcc_io_control

// ---- tcc_io_control_asserts.sv ----
module tcc_io_control_chk #(
  parameter int CNT_W = 16
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [CNT_W-1:0] counter,
  input wire logic [2:0] ch4IoSel,
  input wire logic ch4CaptureMode,
  input wire logic ch4RegAPin,
  input wire logic ch3RegAEvent,
  input wire logic [3:0] ch5IoSel,
  input wire logic ch5InitLoad,
  input wire logic ch5RegAPinIn,
  input wire logic [CNT_W-1:0] ch4GeneralRegA,
  input wire logic ch4Captured,
  input wire logic [CNT_W-1:0] ch5GeneralRegA,
  input wire logic ch5Event,
  input wire logic ch5RegAPinOut,
  input wire logic ch5RegAPinOe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic [2:0] t = ch4IoSel;
  wire logic [3:0] s = ch5IoSel;
  wire logic p = ch4RegAPin;
  wire logic d = ch5RegAPinIn;
  // Compare match that is not overridden by an initial-level load
  wire logic cmpHit = !s[3] && !ch5InitLoad && ch5GeneralRegA == counter;
  property p_4;
    ch4CaptureMode && (t[2] ? ch3RegAEvent : t[1] ? $changed(p) : t[0] ? $fell(p) : $rose(p))
      |=> ch4Captured && ch4GeneralRegA == $past(counter);
  endproperty
  a_4: assert property (p_4) else $error("ch4 capture");
  property p_off4;
    !ch4CaptureMode |=> !ch4Captured;
  endproperty
  a_off4: assert property (p_off4) else $error("ch4 capture outside capture mode");
  property p_oe;
    ch5RegAPinOe == (!s[3] && s[1:0] != 2'h0);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable");
  property p_5;
    s[3] && (s[1] ? $changed(d) : s[0] ? $fell(d) : $rose(d))
      |=> ch5Event && ch5GeneralRegA == $past(counter);
  endproperty
  a_5: assert property (p_5) else $error("ch5 capture");
  property p_init;
    ch5InitLoad |=> ch5RegAPinOut == $past(s[2]);
  endproperty
  a_init: assert property (p_init) else $error("ch5 initial level");
  property p_low;
    cmpHit && s[1:0] == 2'h1 |=> !ch5RegAPinOut;
  endproperty
  a_low: assert property (p_low) else $error("ch5 low on match");
  property p_high;
    cmpHit && s[1:0] == 2'h2 |=> ch5RegAPinOut;
  endproperty
  a_high: assert property (p_high) else $error("ch5 high on match");
  property p_tgl;
    cmpHit && s[1:0] == 2'h3 |=> ch5RegAPinOut != $past(ch5RegAPinOut);
  endproperty
  a_tgl: assert property (p_tgl) else $error("ch5 toggle on match");
endmodule // tcc_io_control_chk
bind tcc_io_control tcc_io_control_chk #(
  .CNT_W(CNT_W)
) tcc_io_control_chk_inst (
  .clock(clock),
  .resetn(resetn),
  .counter(counter),
  .ch4IoSel(ch4IoSel),
  .ch4CaptureMode(ch4CaptureMode),
  .ch4RegAPin(ch4RegAPin),
  .ch3RegAEvent(ch3RegAEvent),
  .ch5IoSel(ch5IoSel),
  .ch5InitLoad(ch5InitLoad),
  .ch5RegAPinIn(ch5RegAPinIn),
  .ch4GeneralRegA(ch4GeneralRegA),
  .ch4Captured(ch4Captured),
  .ch5GeneralRegA(ch5GeneralRegA),
  .ch5Event(ch5Event),
  .ch5RegAPinOut(ch5RegAPinOut),
  .ch5RegAPinOe(ch5RegAPinOe)
);

// ---- tcc_pin_model.sv ----
module tcc_pin_model (
  input wire logic [1:0] lvl,
  input wire logic ch5RegAPinOe,
  input wire logic ch5RegAPinOut,
  output logic ch4RegAPin,
  output logic ch5RegAPinIn
);
  timeunit 1ns;
  timeprecision 100ps;
  // Undriven channel 5 pin follows the external level
  assign ch4RegAPin=lvl[0];
  assign ch5RegAPinIn=ch5RegAPinOe?ch5RegAPinOut:lvl[1];
endmodule // tcc_pin_model

// ---- tcc_io_control_tb.sv ----
module tcc_io_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock=0,resetn=0,ch4CaptureMode=0,ch3RegAEvent=0,ch5InitLoad=0,ch5CompareWrite=0;
  logic [15:0] counter=1,ch5CompareValue=16'h0300,e4=0,e5=0;
  logic [2:0] ch4IoSel=0;
  logic [3:0] ch5IoSel=0;
  logic [1:0] lvl=0;
  wire ch4RegAPin,ch5RegAPinIn,ch4Captured,ch5Event,ch5RegAPinOut,ch5RegAPinOe;
  wire [15:0] ch4GeneralRegA,ch5GeneralRegA;
  int mismatches=0,total_checks=0;
  always #12.5 clock=~clock;
  tcc_io_control tcc_io_control_inst(
    .clock(clock),
    .resetn(resetn),
    .counter(counter),
    .ch4IoSel(ch4IoSel),
    .ch4CaptureMode(ch4CaptureMode),
    .ch4RegAPin(ch4RegAPin),
    .ch3RegAEvent(ch3RegAEvent),
    .ch5IoSel(ch5IoSel),
    .ch5InitLoad(ch5InitLoad),
    .ch5CompareWrite(ch5CompareWrite),
    .ch5CompareValue(ch5CompareValue),
    .ch5RegAPinIn(ch5RegAPinIn),
    .ch4GeneralRegA(ch4GeneralRegA),
    .ch4Captured(ch4Captured),
    .ch5GeneralRegA(ch5GeneralRegA),
    .ch5Event(ch5Event),
    .ch5RegAPinOut(ch5RegAPinOut),
    .ch5RegAPinOe(ch5RegAPinOe)
  );
  tcc_pin_model tcc_pin_model_inst(
    .lvl(lvl),
    .ch5RegAPinOe(ch5RegAPinOe),
    .ch5RegAPinOut(ch5RegAPinOut),
    .ch4RegAPin(ch4RegAPin),
    .ch5RegAPinIn(ch5RegAPinIn)
  );
  task chk(input logic [15:0] g,x);
    total_checks++;
    if(g!==x) begin
      mismatches++;
      $display("BAD %0t mismatch",$time);
    end
  endtask
  task chkBit(input logic g,x);
    total_checks++;
    if(g!==x) begin
      mismatches++;
      $display("BAD %0t bit mismatch",$time);
    end
  endtask
  task wrap_up;
    if(mismatches==0&&total_checks>0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task ev(input logic l,x);
    logic h4,h5;
    counter++;
    // Compare write in capture mode must be ignored
    {ch3RegAEvent,ch5CompareWrite}={x,1'b1};
    h4=ch4CaptureMode&&(x?ch4IoSel[2]:!ch4IoSel[2]&&(ch4IoSel[1]||ch4IoSel[0]!=l));
    h5=!x&&(ch5IoSel[1]||ch5IoSel[0]!=l);
    if(h4) e4=counter;
    if(h5) e5=counter;
    lvl={l,l};
    @(negedge clock) {ch3RegAEvent,ch5CompareWrite}=2'h0;
    chkBit(ch4Captured,h4);
    chkBit(ch5Event,h5);
    @(negedge clock) chk(ch4GeneralRegA,e4);
    chk(ch5GeneralRegA,e5);
    chkBit(ch4Captured,1'b0);
    chkBit(ch5Event,1'b0);
  endtask
  task tc;
    for(int i=0;i<8;i++) begin
      ch4CaptureMode=i<7;
      ch4IoSel=i[2:0];
      ch5IoSel={1'b1,i[2:0]};
      ev(1,0);
      ev(0,0);
      ev(0,1);
    end
  endtask
  task tm;
    for(int k=1;k<8;k++) begin
      ch5IoSel={1'b0,k[2:0]};
      {ch5InitLoad,ch5CompareWrite}=2'h3;
      @(negedge clock) {ch5InitLoad,ch5CompareWrite}=2'h0;
      @(negedge clock) counter=16'h0300;
      if(k!=4) chkBit(ch5RegAPinOut,k[2]);
      chkBit(ch5RegAPinOe,k[1:0]!=0);
      chk(ch5GeneralRegA,16'h0300);
      @(negedge clock) counter=1;
      chkBit(ch5Event,1'b1);
      @(negedge clock) if(k!=4) chkBit(ch5RegAPinOut,k[1]&&!(k[0]&&k[2]));
      chkBit(ch5Event,1'b0);
    end
  endtask
  initial begin
    repeat(16) @(negedge clock);
    resetn=1;
    tc;
    tm;
    wrap_up;
  end
  initial begin
    #20us;
    mismatches++;
    wrap_up;
  end
endmodule // tcc_io_control_tb
